// [core/sdl_pkg.sv]
// shared constants and decode function for the serial dac load control
package sdl_pkg;
  localparam int WORD_W = 16;
  localparam int MSB_W = 4;
  localparam int SEG_W = 15;
  localparam int LADDER_W = 12;
  localparam int CNT_W = 5;
  localparam logic [WORD_W-1:0] MIDSCALE = 16'h8000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // thermometer decode of the top code bits onto the segment switches
  function automatic logic [SEG_W-1:0] seg_decode(
    input logic [MSB_W-1:0] msb
  );
    logic [SEG_W-1:0] seg;
    seg = '0;
    for (int i = 0; i < SEG_W; i++) begin
      seg[i] = (msb > MSB_W'(i));
    end
    return seg;
  endfunction
endpackage

// [core/sdl_if.sv]
// link between host and dac: frame, serial clock, data, control pins
`timescale 1ns/100ps
interface sdl_if;
  logic frame_n;
  logic sclk;
  logic serial_data_in;
  logic load_output_n;
  logic clear_output_n;
  logic power_down_n;
  logic serial_out_drv;
  logic serial_out_oe;
  logic serial_data_out;

  // open-drain line with external pull-up
  assign serial_data_out = serial_out_oe ? serial_out_drv : 1'b1;

  modport dev (
    input frame_n, sclk, serial_data_in, load_output_n,
    input clear_output_n, power_down_n, serial_data_out,
    output serial_out_drv, serial_out_oe
  );
  modport host (
    output frame_n, sclk, serial_data_in, load_output_n,
    output clear_output_n, power_down_n,
    input serial_data_out
  );
endinterface

// [core/sdl_sync.sv]
// two-stage synchroniser for level signals
`timescale 1ns/100ps
module sdl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sdl_sync_s;

  sdl_sync_s sy_r, sy_nxt;

  always_comb begin
    sy_nxt.s1 = d_i;
    sy_nxt.s2 = sy_r.s1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sy_r <= {RST_VAL, RST_VAL};
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign q_o = sy_r.s2;
endmodule // sdl_sync

// [core/sdl_dac_dev.sv]
// dac end: serial shift register on the link clock, load control on clk_i
`timescale 1ns/100ps
// Functional notes
// - shift register is sixteen bits wide
// - reset loads midscale into shift and dac
// - dac code is unsigned straight binary
// - data accepted only while frame is low
// - data sampled on serial clock falling edge
// - host ends frame after sixteenth falling edge
// - frame end copies word into input register
// - load low during frame: update on frame end
// - load high: update on later load falling edge
// - top four bits drive fifteen segments, twelve ladder
// - clear zeroes output until load next low
// - power-down forces zero, writes still accepted
// - clear and load low: both registers, output zero
// - clear low, load high: input register only
// - no clear, load low: output follows code
// - no clear, load high: input register only
// - extra clocks shift old bits onto output
// - frame with load high reads dac register
// - clear leaves register contents untouched
module sdl_dac_dev
  import sdl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  sdl_if.dev link,
  output logic [WORD_W-1:0] input_word_o,
  output logic [WORD_W-1:0] dac_word_o,
  output logic [WORD_W-1:0] out_code_o,
  output logic [SEG_W-1:0] seg_sw_o,
  output logic [LADDER_W-1:0] ladder_sw_o,
  output logic out_zero_o,
  output logic powered_down_o
);
  // link-clock state
  typedef struct packed {
    logic [WORD_W-1:0] shreg;
    // open-drain value of the bit now on the readback line
    logic pull_low;
    // set once sixteen edges have been seen in this frame
    logic full;
  } sdl_lnk_s;

  // core-clock state
  typedef struct packed {
    logic fr_d;
    logic ld_d;
    logic [WORD_W-1:0] in_reg;
    logic [WORD_W-1:0] dac_reg;
    // clear latch: output stays at zero until a load edge or a frame-end update with clear released
    logic zero_hold;
    logic out_zero;
    // power-down as seen on the synchronised pin
    logic pwr_down;
    logic [WORD_W-1:0] out_code;
    logic [SEG_W-1:0] seg;
  } sdl_dev_s;

  localparam sdl_lnk_s LNK_RST = '{
    shreg: MIDSCALE,
    pull_low: 1'b0,
    full: 1'b0
  };

  localparam sdl_dev_s DEV_RST = '{
    fr_d: 1'b1,
    ld_d: 1'b1,
    in_reg: MIDSCALE,
    dac_reg: MIDSCALE,
    zero_hold: 1'b0,
    out_zero: 1'b1,
    pwr_down: 1'b0,
    out_code: MIDSCALE,
    seg: seg_decode(MIDSCALE[WORD_W-1 -: MSB_W])
  };

  sdl_lnk_s lnk_r, lnk_nxt;
  sdl_dev_s dev_r, dev_nxt;
  logic [CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
  logic frame_rst_b;
  logic [3:0] pin_s;
  logic fr_s, ld_s, clear_s, pwrdn_s;
  logic fr_rise, ld_fall, word_done, sync_upd;

  // link clock domain: registers here move on the falling serial edge; the bit counter also clears while frame is high

  // bit counter only lives inside a frame; the clock may stop outside
  assign frame_rst_b = rst_b_i & ~link.frame_n;

  always_comb begin
    lnk_nxt = lnk_r;
    bit_cnt_nxt = bit_cnt_r;
    if (!link.frame_n) begin
      if (bit_cnt_r == '0) begin
        // first edge: dac register is what goes out ahead of the new data
        // the dac register only moves at a frame end or on a load edge
        // outside frames, so it is still while the serial clock runs
        lnk_nxt.pull_low = ~dev_r.dac_reg[WORD_W-1];
        lnk_nxt.shreg = {dev_r.dac_reg[WORD_W-2:0],
                         link.serial_data_in};
      end else begin
        lnk_nxt.pull_low = ~lnk_r.shreg[WORD_W-1];
        lnk_nxt.shreg = {lnk_r.shreg[WORD_W-2:0],
                         link.serial_data_in};
      end
      // saturate at sixteen so a long chain frame cannot wrap the count
      if (bit_cnt_r != CNT_W'(WORD_W)) begin
        bit_cnt_nxt = bit_cnt_r + 1'b1;
      end
      // a whole word is held once sixteen edges have been seen
      lnk_nxt.full = (bit_cnt_r >= CNT_W'(WORD_W - 1));
    end
  end

  always_ff @(negedge link.sclk or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk_r <= LNK_RST;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  always_ff @(negedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      bit_cnt_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // open drain: pull low only, released in power-down
  assign link.serial_out_drv = 1'b0;
  assign link.serial_out_oe = lnk_r.pull_low & link.power_down_n;

  // core clock domain: pins arrive through two flip-flops

  sdl_sync #(
    .W(4),
    .RST_VAL(4'hf)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({link.frame_n, link.load_output_n,
          link.clear_output_n, link.power_down_n}),
    .q_o(pin_s)
  );

  assign fr_s = pin_s[3];
  assign ld_s = pin_s[2];
  assign clear_s = pin_s[1];
  assign pwrdn_s = pin_s[0];
  assign fr_rise = fr_s & ~dev_r.fr_d;
  assign ld_fall = ~ld_s & dev_r.ld_d;
  // the synchronised frame rise is the handshake for the shift word:
  // by then the serial clock has stopped, so shift word and full flag
  // are still and may be read on this clock
  assign word_done = fr_rise & lnk_r.full;
  assign sync_upd = word_done & ~ld_s;

  always_comb begin
    dev_nxt = dev_r;
    dev_nxt.fr_d = fr_s;
    dev_nxt.ld_d = ld_s;
    dev_nxt.pwr_down = ~pwrdn_s;
    // register writes go ahead whatever clear and power-down say
    if (word_done) begin
      dev_nxt.in_reg = lnk_r.shreg;
    end
    if (sync_upd) begin
      dev_nxt.dac_reg = lnk_r.shreg;
    end else if (ld_fall && fr_s) begin
      dev_nxt.dac_reg = dev_r.in_reg;
    end
    // clear only affects the output path, never the registers
    if (!clear_s) begin
      dev_nxt.zero_hold = 1'b1;
    end else if (ld_fall || sync_upd) begin
      dev_nxt.zero_hold = 1'b0;
    end
    // power-down first, then clear, then the dac code
    dev_nxt.out_zero = ~pwrdn_s | ~clear_s
                       | dev_nxt.zero_hold;
    // zero volts is midscale in straight binary
    if (dev_nxt.out_zero) begin
      dev_nxt.out_code = MIDSCALE;
    end else begin
      dev_nxt.out_code = dev_nxt.dac_reg;
    end
    dev_nxt.seg = seg_decode(dev_nxt.dac_reg[WORD_W-1 -: MSB_W]);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dev_r <= DEV_RST;
    end else begin
      dev_r <= dev_nxt;
    end
  end

  assign input_word_o = dev_r.in_reg;
  assign dac_word_o = dev_r.dac_reg;
  assign out_code_o = dev_r.out_code;
  assign seg_sw_o = dev_r.seg;
  // low twelve code bits drive the ladder switches one to one
  assign ladder_sw_o = dev_r.dac_reg[LADDER_W-1:0];
  assign out_zero_o = dev_r.out_zero;
  assign powered_down_o = dev_r.pwr_down;
endmodule // sdl_dac_dev

// [core/sdl_dac_host.sv]
// host end: drives frame, divided serial clock, data and control pins
`timescale 1ns/100ps
module sdl_dac_host
  import sdl_pkg::*;
#(
  parameter int FRAME_BITS = WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  sdl_if.host link,
  input wire logic wr_start_i,
  input wire logic [WORD_W-1:0] wr_word_i,
  input wire logic sync_load_i,
  input wire logic load_pulse_i,
  input wire logic clear_output_n_i,
  input wire logic power_down_n_i,
  output logic busy_o,
  output logic [WORD_W-1:0] rd_word_o,
  output logic rd_valid_o
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_SETUP = 6'b000010,
    H_LOW = 6'b000100,
    H_HIGH = 6'b001000,
    H_END = 6'b010000,
    H_LDP = 6'b100000
  } sdl_hst_e;

  typedef struct packed {
    sdl_hst_e st;
    logic [7:0] div;
    logic [7:0] bits;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic [WORD_W-1:0] rd_word;
    logic rd_valid;
    logic sclk;
    logic frame_n;
    logic data_bit;
    logic load_n;
    logic clear_n;
    logic pwrdn_n;
  } sdl_hst_s;

  localparam sdl_hst_s HST_RST = '{
    st: H_IDLE, div: 8'h00, bits: 8'h00, tx: '0, rx: '0,
    rd_word: '0, rd_valid: 1'b0, sclk: 1'b1, frame_n: 1'b1,
    data_bit: 1'b0, load_n: 1'b1, clear_n: 1'b1, pwrdn_n: 1'b1
  };

  sdl_hst_s h_r, h_nxt;
  logic rdbk_s;
  logic half_done;

  sdl_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_rdbk_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(link.serial_data_out),
    .q_o(rdbk_s)
  );

  assign half_done = (h_r.div == 8'(SCLK_HALF_CYC - 1));

  always_comb begin
    h_nxt = h_r;
    h_nxt.rd_valid = 1'b0;
    h_nxt.clear_n = clear_output_n_i;
    h_nxt.pwrdn_n = power_down_n_i;
    h_nxt.div = half_done ? 8'h00 : h_r.div + 8'h01;
    unique case (h_r.st)
      H_IDLE: begin
        h_nxt.div = 8'h00;
        if (wr_start_i) begin
          h_nxt.st = H_SETUP;
          h_nxt.frame_n = 1'b0;
          h_nxt.tx = wr_word_i;
          h_nxt.data_bit = wr_word_i[WORD_W-1];
          h_nxt.bits = 8'h00;
          h_nxt.load_n = ~sync_load_i;
        end else if (load_pulse_i) begin
          h_nxt.st = H_LDP;
          h_nxt.load_n = 1'b0;
        end
      end
      H_SETUP: begin
        if (half_done) begin
          h_nxt.st = H_LOW;
          h_nxt.sclk = 1'b0;
        end
      end
      H_LOW: begin
        if (half_done) begin
          h_nxt.st = H_HIGH;
          h_nxt.sclk = 1'b1;
          h_nxt.rx = {h_r.rx[WORD_W-2:0], rdbk_s};
          h_nxt.bits = h_r.bits + 8'h01;
          h_nxt.tx = {h_r.tx[WORD_W-2:0], 1'b0};
          h_nxt.data_bit = h_r.tx[WORD_W-2];
        end
      end
      H_HIGH: begin
        if (half_done) begin
          if (h_r.bits == 8'(FRAME_BITS)) begin
            h_nxt.st = H_END;
            h_nxt.frame_n = 1'b1;
          end else begin
            h_nxt.st = H_LOW;
            h_nxt.sclk = 1'b0;
          end
        end
      end
      H_END: begin
        if (half_done) begin
          h_nxt.st = H_IDLE;
          h_nxt.load_n = 1'b1;
          h_nxt.rd_word = h_r.rx;
          h_nxt.rd_valid = 1'b1;
        end
      end
      H_LDP: begin
        if (half_done) begin
          h_nxt.st = H_IDLE;
          h_nxt.load_n = 1'b1;
        end
      end
      default: begin
        h_nxt = HST_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_r <= HST_RST;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.frame_n = h_r.frame_n;
  assign link.sclk = h_r.sclk;
  assign link.serial_data_in = h_r.data_bit;
  assign link.load_output_n = h_r.load_n;
  assign link.clear_output_n = h_r.clear_n;
  assign link.power_down_n = h_r.pwrdn_n;
  assign busy_o = (h_r.st != H_IDLE);
  assign rd_word_o = h_r.rd_word;
  assign rd_valid_o = h_r.rd_valid;
endmodule // sdl_dac_host

// [dv/sdl_sva.sv]
// link timing checks between host end and dac end
`timescale 1ns/100ps
module sdl_sva (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic load_output_n,
  input wire logic power_down_n,
  input wire logic serial_out_oe
);
  logic sclk_q_r;
  logic [4:0] falls_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // serial clock falls seen inside the current frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q_r <= 1'b1;
      falls_r <= '0;
    end else begin
      sclk_q_r <= sclk;
      if (frame_n) begin
        falls_r <= '0;
      end else if (sclk_q_r && !sclk) begin
        falls_r <= falls_r + 5'h01;
      end
    end
  end
  idle_clock_a: assert property (frame_n |-> sclk)
    else $error("serial clock low outside a frame");
  frame_len_a: assert property ($rose(frame_n) |-> falls_r == 5'h10)
    else $error("frame not ended after sixteen falls");
  first_fall_a: assert property (
    $fell(frame_n) |-> sclk [*5] ##1 !sclk)
    else $error("first serial clock fall misplaced");
  data_stable_a: assert property (
    $fell(sclk) |-> $stable(serial_data_in))
    else $error("serial data moved at sampling edge");
  half_period_a: assert property (
    $fell(sclk) |-> !sclk [*5] ##1 sclk)
    else $error("serial clock low phase wrong");
  load_hold_a: assert property (
    !frame_n && !$past(frame_n) |-> $stable(load_output_n))
    else $error("load line moved inside a frame");
  frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*4])
    else $error("frame gap too short");
  async_pulse_a: assert property (
    $fell(load_output_n) && frame_n |-> !load_output_n [*5] ##1 load_output_n)
    else $error("async load pulse width wrong");
  pwrdn_float_a: assert property (
    !power_down_n |-> !serial_out_oe)
    else $error("serial output driven in power-down");
endmodule // sdl_sva

// [dv/tb_top.sv]
// self-checking bench: host end drives dac end over the link
`timescale 1ns/100ps
module tb_top;
  import sdl_pkg::*;
  logic clk_i, rst_b_i, wr_start_i, sync_load_i, load_pulse_i;
  logic clear_output_n_i, power_down_n_i, busy_o, rd_valid_o;
  logic out_zero_o, powered_down_o, e_zero;
  logic [WORD_W-1:0] wr_word_i, rd_word_o, input_word_o, dac_word_o;
  logic [WORD_W-1:0] out_code_o, e_in, e_dac;
  logic [SEG_W-1:0] seg_sw_o;
  logic [LADDER_W-1:0] ladder_sw_o;
  logic [31:0] lfsr;
  int mismatches, cmp_count;
  sdl_if link ();
  sdl_dac_host i_sdl_dac_host (.clk_i, .rst_b_i, .link(link.host),
    .wr_start_i, .wr_word_i, .sync_load_i, .load_pulse_i,
    .clear_output_n_i, .power_down_n_i, .busy_o, .rd_word_o, .rd_valid_o);
  sdl_dac_dev i_sdl_dac_dev (.clk_i, .rst_b_i, .link(link.dev),
    .input_word_o, .dac_word_o, .out_code_o, .seg_sw_o, .ladder_sw_o,
    .out_zero_o, .powered_down_o);
  sdl_sva i_sdl_sva (.clk_i, .rst_b_i, .frame_n(link.frame_n),
    .sclk(link.sclk), .serial_data_in(link.serial_data_in),
    .load_output_n(link.load_output_n), .power_down_n(link.power_down_n),
    .serial_out_oe(link.serial_out_oe));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [SEG_W-1:0] therm(input logic [3:0] m);
    return SEG_W'((16'h0001 << m) - 16'h0001);
  endfunction
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_all();
    logic z;
    z = e_zero || !power_down_n_i;
    chk("input_word", input_word_o, e_in);
    chk("dac_word", dac_word_o, e_dac);
    chk("ladder", 16'(ladder_sw_o), 16'(e_dac[11:0]));
    chk("seg", 16'(seg_sw_o), 16'(therm(e_dac[15:12])));
    chk("out_zero", 16'(out_zero_o), 16'(z));
    chk("out_code", out_code_o, z ? MIDSCALE : e_dac);
  endtask
  // bounded wait on a completion level: sel 0 is busy_o, 1 is rd_valid_o
  task automatic wait_for(input bit sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? rd_valid_o : busy_o) !== lvl && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if ((sel ? rd_valid_o : busy_o) !== lvl) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [15:0] w, input logic s);
    wait_for(1'b0, 1'b0);
    wr_word_i = w;
    sync_load_i = s;
    wr_start_i = 1'b1;
    @(negedge clk_i);
    wr_start_i = 1'b0;
    wait_for(1'b1, 1'b1);
    chk("readback", rd_word_o, power_down_n_i ? e_dac : 16'hffff);
    e_in = w;
    if (s) begin
      e_dac = w;
      if (clear_output_n_i) e_zero = 1'b0;
    end
    repeat (5) @(negedge clk_i);
    chk_all();
  endtask
  task automatic pulse();
    wait_for(1'b0, 1'b0);
    load_pulse_i = 1'b1;
    @(negedge clk_i);
    load_pulse_i = 1'b0;
    wait_for(1'b0, 1'b0);
    repeat (6) @(negedge clk_i);
    e_dac = e_in;
    if (clear_output_n_i) e_zero = 1'b0;
    chk_all();
  endtask
  task automatic pins(input logic c, input logic p);
    clear_output_n_i = c;
    power_down_n_i = p;
    if (!c) e_zero = 1'b1;
    repeat (8) @(negedge clk_i);
    chk_all();
    chk("powered_down", 16'(powered_down_o), 16'(!p));
  endtask
  initial begin
    lfsr = 32'hcae0c7f5;
    {wr_start_i, wr_word_i, sync_load_i, load_pulse_i} = '0;
    clear_output_n_i = 1'b1;
    power_down_n_i = 1'b1;
    rst_b_i = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    e_in = MIDSCALE;
    e_dac = MIDSCALE;
    e_zero = 1'b1;
    repeat (16) @(negedge clk_i);
    chk_all();
    rst_b_i = 1'b1;
    e_zero = 1'b0;
    repeat (5) @(negedge clk_i);
    chk_all();
    wr(16'h0000, 1'b1);
    wr(16'hffff, 1'b1);
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(lfsr[15:0], lfsr[16]);
      if (lfsr[17]) pulse();
    end
    wr(16'h1234, 1'b0);
    pulse();
    pins(1'b0, 1'b1);
    wr(16'h4321, 1'b0);
    wr(16'h0f0f, 1'b1);
    pins(1'b1, 1'b1);
    pulse();
    pins(1'b1, 1'b0);
    wr(16'hc3a5, 1'b1);
    pins(1'b1, 1'b1);
    end_of_test();
  end
endmodule // tb_top
